/* File: rtl/idcs_sequencer.sv */
// Acknowledge cycle sequencer: stretches the processor acknowledge cycle and
// times the internal strobes of the serial controller and counter-timer.
// Assumes the outside peripheral sits above the on-chip ones in the chain.
// Overview of operation
// RULE_01: Outside chain peripherals sit at higher priority.
// RULE_02: Outside peripheral passes enable within two clocks.
// RULE_03: Acknowledge gets three added waits, five total.
// RULE_04: Serial ack strobe starts at first state fall.
// RULE_05: Serial read strobe starts on fourth wait rise.
// RULE_06: Counter request starts with serial read strobe.
// RULE_07: Outside request starts at first auto-wait fall.
// RULE_08: Outside peripheral settles within two clocks.
// RULE_09: Lower-priority outside peripheral needs delayed request.
// RULE_10: Master leaves four clocks between serial accesses.
// RULE_11: Hold acknowledge in wait until waits expire.
`timescale 1ns/1ps
module idcs_sequencer (
  // Clock, reset, enable
  input  wire logic  i_sys_clk,
  input  wire logic  i_rstn,
  input  wire logic  i_clk_en,
  // Processor side
  input  wire logic  i_serial_ack_strobe_req,
  input  wire logic  i_chain_top,
  output logic       o_cpu_wait,
  output logic       o_cpu_done,
  output logic [7:0] o_vector,
  output logic       o_vector_valid,
  // On-chip peripherals
  output logic       o_serial_ack_strobe_n,
  output logic       o_serial_read_strobe_n,
  output logic       o_ctr_io_request_strobe_n,
  // Chain link
  idcs_link_if.dev   link
);
  // All posedge state lives in one packed word; the two strobes that are due
  // on a falling edge are copied into a second, negedge phase so that every
  // output except the chain enable still leaves a flop.
  typedef struct packed {
    idcs_pkg::idcs_state_t st;
    logic [2:0]            wcnt;
    logic                  fetch_n;
    logic                  ioreq_n;
    logic                  sack_n;
    logic                  srd_n;
    logic                  ctr_n;
    logic                  wait_o;
    logic                  done;
    logic [7:0]            vec;
    logic                  vvld;
  } idcs_seq_t;

  // Registered state and its next value
  idcs_seq_t s_q;
  idcs_seq_t s_d;

  // Falling-edge phase register: strobes due on a fall are taken from here
  logic fall_sack_q;
  logic fall_io_q;

  // Wait indices run 1 up to the total. A strobe that must be low in a given
  // wait is loaded on the rise that opens it, so the match is one index early.
  function automatic logic idcs_strobe_due(input logic [2:0] wcnt);
    logic [2:0] due;
    due = idcs_pkg::STROBE_WAIT - 3'h1;
    return (wcnt == due);
  endfunction : idcs_strobe_due

  // True in the last wait of the stretched cycle
  function automatic logic idcs_last_wait(input logic [2:0] wcnt);
    return (wcnt == idcs_pkg::TOTAL_WAITS);
  endfunction : idcs_last_wait

  // Advance the wait index; the last-wait test stops it before it can wrap
  function automatic logic [2:0] idcs_next_wait(input logic [2:0] wcnt);
    logic [3:0] sum;
    sum = {1'b0, wcnt} + 4'h1;
    return sum[2:0];
  endfunction : idcs_next_wait

  // Return every strobe of the cycle to its idle (high) level
  function automatic idcs_seq_t idcs_release(input idcs_seq_t s);
    idcs_seq_t r;
    r         = s;
    r.fetch_n = 1'b1;
    r.ioreq_n = 1'b1;
    r.sack_n  = 1'b1;
    r.srd_n   = 1'b1;
    r.ctr_n   = 1'b1;
    return r;
  endfunction : idcs_release

  // Half a clock of delay, no decoding: the fall phase only copies levels
  always_ff @(negedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      fall_sack_q <= 1'b1;
      fall_io_q   <= 1'b1;
    end else if (i_clk_en) begin
      fall_sack_q <= s_q.sack_n;
      fall_io_q   <= s_q.ioreq_n;
    end
  end

  // One pass through the stretched cycle: first state, second state, the
  // waits, the last state, then idle again. Every strobe is released in one
  // place so that no strobe can outlive the cycle.
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.vvld = 1'b0;
    unique case (s_q.st)
      idcs_pkg::IDCS_IDLE: begin
        // Requests are only looked at here; one made while busy is dropped
        if (i_serial_ack_strobe_req) begin
          s_d.st      = idcs_pkg::IDCS_FIRST;
          s_d.fetch_n = 1'b0;
          s_d.sack_n  = 1'b0; // RULE_04
          s_d.wait_o  = 1'b1; // RULE_11
        end
      end

      idcs_pkg::IDCS_FIRST: begin
        // The ack strobe shows at the fall inside this state
        s_d.st = idcs_pkg::IDCS_SECOND;
      end

      idcs_pkg::IDCS_SECOND: begin
        // The outside request is loaded here and shows at the next fall,
        // which is the fall of the first automatic wait
        s_d.st      = idcs_pkg::IDCS_WAIT;
        s_d.wcnt    = 3'h1;
        s_d.ioreq_n = 1'b0; // RULE_07
      end

      idcs_pkg::IDCS_WAIT: begin
        // Read and counter strobes start together so both settle times end at once
        if (idcs_strobe_due(s_q.wcnt)) begin
          s_d.srd_n = 1'b0; // RULE_05
          s_d.ctr_n = 1'b0; // RULE_06
        end
        // Wait stays high through the last wait and drops on leaving it
        if (idcs_last_wait(s_q.wcnt)) begin // RULE_03
          s_d.st     = idcs_pkg::IDCS_LAST;
          s_d.wait_o = 1'b0; // RULE_11
        end else begin
          s_d.wcnt = idcs_next_wait(s_q.wcnt); // RULE_03
        end
      end

      idcs_pkg::IDCS_LAST: begin
        s_d      = idcs_release(s_q);
        s_d.st   = idcs_pkg::IDCS_IDLE;
        s_d.wcnt = 3'h0;
        s_d.done = 1'b1;
        // The vector is taken only from an outside peripheral that drives it
        // and keeps the chain closed below itself; the on-chip units answer
        // through their own path, which this block does not carry.
        if (link.vector_oe && !link.chain_enable_out) begin // RULE_01
          s_d.vec  = link.vector_out;
          s_d.vvld = 1'b1;
        end else begin
          s_d.vec  = 8'h00;
          s_d.vvld = 1'b0;
        end
      end

      default: begin
        // Codes outside the enum: back to idle with all strobes released
        s_d        = idcs_release(s_q);
        s_d.st     = idcs_pkg::IDCS_IDLE;
        s_d.wcnt   = 3'h0;
        s_d.wait_o = 1'b0;
      end
    endcase
  end

  // Clock enable low freezes every field; a cycle in progress resumes where
  // it stopped, so the processor sees a longer but otherwise intact cycle.
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_q.st      <= idcs_pkg::IDCS_IDLE;
      s_q.wcnt    <= 3'h0;
      s_q.fetch_n <= 1'b1;
      s_q.ioreq_n <= 1'b1;
      s_q.sack_n  <= 1'b1;
      s_q.srd_n   <= 1'b1;
      s_q.ctr_n   <= 1'b1;
      s_q.wait_o  <= 1'b0;
      s_q.done    <= 1'b0;
      s_q.vec     <= 8'h00;
      s_q.vvld    <= 1'b0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the two register phases; the chain enable
  // fed to the top of the chain is a plain pass of the input level.
  assign o_cpu_wait                = s_q.wait_o;
  assign o_cpu_done                = s_q.done;
  assign o_vector                  = s_q.vec;
  assign o_vector_valid            = s_q.vvld;
  assign o_serial_ack_strobe_n     = fall_sack_q;
  assign o_serial_read_strobe_n    = s_q.srd_n;
  assign o_ctr_io_request_strobe_n = s_q.ctr_n;
  assign link.opcode_fetch_strobe_n = s_q.fetch_n;
  assign link.io_request_strobe_n   = fall_io_q;
  assign link.chain_enable_in       = i_chain_top;
endmodule : idcs_sequencer

/* File: rtl/idcs_pkg.sv */
// Package for the interrupt acknowledge sequencer and the external chain peripheral.
// Assumes one system clock shared by both ends.
package idcs_pkg;
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  // Wait counts of the processor acknowledge cycle
  localparam logic [2:0]  AUTO_WAITS      = 3'h2;
  localparam logic [2:0]  ADDED_WAITS     = 3'h3;
  localparam logic [2:0]  TOTAL_WAITS     = AUTO_WAITS + ADDED_WAITS;
  // Wait index (1 based) on whose rise the read and counter strobes start
  localparam logic [2:0]  STROBE_WAIT     = 3'h4;
  // Chain pass-through limit of the outside peripheral, in clocks
  localparam logic [2:0]  CHAIN_PASS_MAX  = 3'h2;
  // Least recovery between serial controller accesses, in clocks
  localparam logic [2:0]  RECOVERY_CLKS   = 3'h4;

  typedef enum logic [2:0] {
    IDCS_IDLE  = 3'b000,
    IDCS_FIRST  = 3'b001,
    IDCS_SECOND = 3'b010,
    IDCS_WAIT   = 3'b011,
    IDCS_LAST   = 3'b100
  } idcs_state_t;
endpackage : idcs_pkg

/* File: rtl/idcs_link_if.sv */
// Interface joining the on-chip sequencer and an outside chain peripheral.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface idcs_link_if;
  logic opcode_fetch_strobe_n;
  logic io_request_strobe_n;
  logic chain_enable_in;
  logic chain_enable_out;
  logic vector_oe;
  logic [7:0] vector_out;

  modport dev (
    output opcode_fetch_strobe_n,
    output io_request_strobe_n,
    output chain_enable_in,
    input  chain_enable_out,
    input  vector_oe,
    input  vector_out
  );
  modport per (
    input  opcode_fetch_strobe_n,
    input  io_request_strobe_n,
    input  chain_enable_in,
    output chain_enable_out,
    output vector_oe,
    output vector_out
  );
endinterface : idcs_link_if

/* File: rtl/idcs_chain_peripheral.sv */
// Outside chain peripheral: passes the chain enable and answers acknowledge.
// Assumes the sequencer strobes are on the same system clock.
`timescale 1ns/1ps
module idcs_chain_peripheral #(
  parameter logic [7:0] VECTOR = 8'h40
) (
  // Clock, reset, enable
  input  wire logic i_sys_clk,
  input  wire logic i_rstn,
  input  wire logic i_clk_en,
  // User side
  input  wire logic i_irq,
  output logic      o_served,
  // Chain link
  idcs_link_if.per  link
);
  typedef struct packed {
    logic pend;
    logic en_out;
    logic oe;
    logic served;
  } idcs_per_t;

  idcs_per_t p_q;
  idcs_per_t p_d;

  always_comb begin
    p_d        = p_q;
    p_d.served = 1'b0;
    if (i_irq) begin
      p_d.pend = 1'b1;
    end
    // Enable passes in one clock, inside the two-clock limit
    p_d.en_out = link.chain_enable_in && !p_q.pend; // RULE_02 RULE_08
    // Drive the vector while acknowledged, the request is at the fall of the first auto wait
    p_d.oe = !link.opcode_fetch_strobe_n && !link.io_request_strobe_n
             && link.chain_enable_in && p_q.pend; // RULE_01 RULE_09
    if (p_q.oe && link.opcode_fetch_strobe_n) begin
      p_d.pend   = i_irq;
      p_d.served = 1'b1;
      p_d.oe     = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      p_q <= '0;
    end else if (i_clk_en) begin
      p_q <= p_d;
    end
  end

  assign o_served              = p_q.served;
  assign link.chain_enable_out = p_q.en_out;
  assign link.vector_oe        = p_q.oe;
  assign link.vector_out       = VECTOR;
endmodule : idcs_chain_peripheral

/* File: verification/idcs_link_chk.sv */
// Checker on the link between the acknowledge sequencer and the chain peripheral.
// Assumes one system clock and the shared active-low reset.
`timescale 1ns/1ps
module idcs_link_chk (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic opcode_fetch_strobe_n,
  input wire logic io_request_strobe_n,
  input wire logic chain_enable_in,
  input wire logic chain_enable_out,
  input wire logic vector_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_fetch_hold;
    (!opcode_fetch_strobe_n) [*7] ##1 opcode_fetch_strobe_n;
  endsequence
  property p_fetch_len; $fell(opcode_fetch_strobe_n) |-> ##1 s_fetch_hold; endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("fetch length");
  property p_io_after; $fell(opcode_fetch_strobe_n) |-> ##2 $fell(io_request_strobe_n); endproperty
  a_io_after: assert property (p_io_after) else $error("io request timing");
  property p_io_within; !io_request_strobe_n |-> !opcode_fetch_strobe_n; endproperty
  a_io_within: assert property (p_io_within) else $error("io outside cycle");
  property p_gap; $rose(opcode_fetch_strobe_n) |-> ##1 opcode_fetch_strobe_n; endproperty
  a_gap: assert property (p_gap) else $error("fetch gap");
  property p_en_out; $fell(chain_enable_in) |-> ##[0:2] !chain_enable_out; endproperty
  a_en_out: assert property (p_en_out) else $error("enable pass");
  property p_oe_cause;
    $rose(vector_oe) |-> $past(!io_request_strobe_n) && $past(chain_enable_in);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("vector drive cause");
  property p_oe_out; vector_oe |-> !chain_enable_out; endproperty
  a_oe_out: assert property (p_oe_out) else $error("enable while answering");
  property p_oe_rel; $rose(opcode_fetch_strobe_n) |-> ##[1:2] !vector_oe; endproperty
  a_oe_rel: assert property (p_oe_rel) else $error("vector release");
endmodule : idcs_link_chk

/* File: verification/test_serial_ack_strobe_daisy_chain_sequencer.sv */
// Bench: sequencer joined to one outside chain peripheral.
// Assumes the design files are compiled first.
`timescale 1ns/1ps
module test_serial_ack_strobe_daisy_chain_sequencer;
  logic        i_sys_clk = 0, i_rstn = 0, i_req = 0, i_top = 0, i_irq = 0, i_en = 1;
  logic        cpu_wait, done, valid, s_ack, s_rd, s_ctr, w_q = 0, e, served, pend_m = 0;
  logic [7:0]  vec;
  logic [3:0]  cnt, f_ack, f_rd, f_ctr, f_io, n_w;
  logic [28:0] exp_q[$];
  int          n_mismatch = 0, checks = 0, n_srv = 0, n_ans = 0;
  idcs_link_if link ();
  idcs_sequencer idcs_sequencer_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_clk_en(i_en),
    .i_serial_ack_strobe_req(i_req), .i_chain_top(i_top), .o_cpu_wait(cpu_wait), .o_cpu_done(done),
    .o_vector(vec), .o_vector_valid(valid), .o_serial_ack_strobe_n(s_ack),
    .o_serial_read_strobe_n(s_rd), .o_ctr_io_request_strobe_n(s_ctr), .link(link.dev));
  idcs_chain_peripheral #(.VECTOR(8'h5a)) idcs_chain_peripheral_inst (.i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn), .i_clk_en(i_en), .i_irq(i_irq), .o_served(served), .link(link.per));
  idcs_link_chk idcs_link_chk_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .opcode_fetch_strobe_n(link.opcode_fetch_strobe_n),
    .io_request_strobe_n(link.io_request_strobe_n), .chain_enable_in(link.chain_enable_in),
    .chain_enable_out(link.chain_enable_out), .vector_oe(link.vector_oe));
  always #2.5 i_sys_clk = ~i_sys_clk;
  task automatic check(input logic [28:0] seen, input logic [28:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  // Strobe offsets are counted in clocks from the first edge of the stretched cycle
  always @(posedge i_sys_clk) begin
    logic [28:0] seen;
    #1;
    if (cpu_wait === 1'b1 && !w_q) begin
      cnt = 1; f_ack = 0; f_rd = 0; f_ctr = 0; f_io = 0; n_w = 0;
    end else cnt = cnt + 1;
    w_q = (cpu_wait === 1'b1);
    if (w_q) n_w = n_w + 1;
    if (s_ack === 1'b0 && f_ack == 0) f_ack = cnt;
    if (s_rd === 1'b0 && f_rd == 0) f_rd = cnt;
    if (s_ctr === 1'b0 && f_ctr == 0) f_ctr = cnt;
    if (link.io_request_strobe_n === 1'b0 && f_io == 0) f_io = cnt;
    if (served === 1'b1) n_srv++;
    if (done === 1'b1) begin
      seen = {f_ack, f_rd, f_ctr, f_io, n_w, valid, valid ? vec : 8'h00};
      check(seen, exp_q.pop_front());
    end
  end
  initial begin
    logic ok;
    void'($urandom(32'h656f));
    repeat (5) @(negedge i_sys_clk);
    i_rstn = 1;
    ok = 1;
    for (int t = 0; t < 16 && ok; t++) begin
      @(negedge i_sys_clk);
      if (t % 4 == 3) begin
        // A request offered while the clock enable is low must not start a cycle
        i_en  = 0;
        i_req = 1;
        repeat (3) @(negedge i_sys_clk);
        i_req = 0;
        i_en  = 1;
        @(negedge i_sys_clk);
        check({28'h0, cpu_wait}, 29'h0);
      end
      i_irq = 1'($urandom);
      i_top = 1'($urandom);
      // A request left unanswered stays pending until the chain reaches it
      e      = (pend_m | i_irq) & i_top;
      pend_m = (pend_m | i_irq) & !e;
      if (e) n_ans++;
      repeat (3) @(negedge i_sys_clk);
      exp_q.push_back({4'h2, 4'h6, 4'h6, 4'h4, 4'(idcs_pkg::TOTAL_WAITS) + 4'h2, e,
                       e ? 8'h5a : 8'h00});
      i_req = 1;
      @(negedge i_sys_clk);
      i_req = 0;
      ok = 0;
      repeat (20) if (!ok) begin
        @(negedge i_sys_clk);
        ok = (done === 1'b1);
      end
      i_irq = 0;
      $display("test %0d answered %0d top %0d finished %0d", t, e, i_top, ok);
    end
    if (!ok) n_mismatch++;
    repeat (3) @(negedge i_sys_clk);
    check(29'(n_srv), 29'(n_ans));
    summarize();
  end
endmodule : test_serial_ack_strobe_daisy_chain_sequencer
